// [esm_ctrl.sv]
// external data-move steering, address mapping and bus timing engine
//
// What this block does
// R1 - mode 00: all moves go to on-chip ram
// R2 - internal-only addresses wrap on 8 kB
// R3 - 8-bit address: page high, index low
// R4 - 16-bit address from data pointer
// R5 - split modes: above ram size go off-chip
// R6 - split no-bank 8-bit: upper lines undriven
// R7 - split 16-bit off-chip drives the upper lines; low lines only with mux select set
// R8 - mode 10 8-bit drives page on top
// R9 - mode 11: every move off-chip
// R10 - external-only 8-bit ignores page, upper undriven
// R11 - setup clocks from timing bits 7:6
// R12 - strobe lasts width field plus one
// R13 - address hold from timing bits 1:0
// R14 - off-chip move adds four clock overhead
// R15 - minimum non-muxed off-chip move five clocks
// R16 - muxed latch phase adds two clocks minimum
// R17 - timing fields reset to maximum codes
// R18 - mux select set means non-muxed timing
// R19 - bank select only for combination 10
// R20 - mux select zero shares data/low address
// R21 - latch high and low last code+1
// R22 - low address on shared pins while latch high
// R23 - setup, strobe, hold; no strobe on-chip
// R24 - memory returns read data before strobe ends
`timescale 1ns/1ps
`include "esm_defs.svh"

module esm_ctrl #(
   parameter int RAM_AW = `ESM_RAM_AW_DEF
) (
   input  wire logic        clk_sys,
   input  wire logic        sys_rst,
   // special function register port
   input  wire logic [7:0]  sfr_addr,
   input  wire logic        sfr_wr,
   input  wire logic [7:0]  sfr_wdata,
   output logic      [7:0]  sfr_rdata,
   // data-move request from the core
   input  wire logic        mv_req,
   input  wire logic        mv_wr,
   input  wire logic        mv_is16,
   input  wire logic        mv_sel_one,
   input  wire logic [15:0] data_pointer,
   input  wire logic [7:0]  index_register_zero,
   input  wire logic [7:0]  index_register_one,
   input  wire logic [7:0]  mv_wdata,
   output logic             mv_busy,
   output logic             mv_done,
   output logic      [7:0]  mv_rdata,
   // external bus pins
   output logic      [15:0] ext_addr_o,
   output logic             ext_addr_hi_oe,
   output logic             ext_addr_lo_oe,
   input  wire logic [7:0]  ext_ad_i,
   output logic      [7:0]  ext_ad_o,
   output logic             ext_ad_oe,
   output logic             ext_ale,
   output logic             ext_rd_n,
   output logic             ext_wr_n
);

   // ---------------------------------------------------------------
   // parameter check
   // ---------------------------------------------------------------
   if (RAM_AW < 8 || RAM_AW > 15) begin : g_bad_aw
      $error("esm_ctrl: RAM_AW must lie between 8 and 15");
   end

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      esm_pkg::esm_state_t st;
      logic [3:0]          cnt;
      logic [15:0]         addr;
      logic                hi_oe;
      logic                wr;
      logic [7:0]          wdata;
      logic [7:0]          rdata;
      logic                done;
      logic [7:0]          timing;
      logic                mux_sel;
      logic [1:0]          mode;
      logic [1:0]          ale_w;
      logic [7:0]          page;
   } esm_regs_t;

   esm_regs_t s_q;
   esm_regs_t s_d;

   logic [RAM_AW-1:0] ram_addr;
   logic              ram_we;
   logic [7:0]        ram_rdata;
   logic [15:0]       eff_addr;
   logic              off_chip;
   logic              drive_hi;
   logic [1:0]        setup_f;
   logic [3:0]        width_f;
   logic [1:0]        hold_f;
   logic              bus_active;

   // ---------------------------------------------------------------
   // timing field views
   // ---------------------------------------------------------------
   assign setup_f = s_q.timing[`ESM_TC_SETUP_HI:`ESM_TC_SETUP_LO]; // see R11
   assign width_f = s_q.timing[`ESM_TC_WIDTH_HI:`ESM_TC_WIDTH_LO]; // see R12
   assign hold_f  = s_q.timing[`ESM_TC_HOLD_HI:`ESM_TC_HOLD_LO];   // see R13

   // ---------------------------------------------------------------
   // address forming and routing decision
   // ---------------------------------------------------------------
   always_comb begin
      // 16-bit moves take the pointer, 8-bit the page (zero in mode 11) and an index
      if (mv_is16) begin
         eff_addr = data_pointer;                        // see R4
      end else if (s_q.mode == `ESM_MODE_EXT_ONLY) begin
         eff_addr = {8'h00, mv_sel_one ? index_register_one
                                       : index_register_zero}; // see R10
      end else begin
         eff_addr = {s_q.page, mv_sel_one ? index_register_one
                                          : index_register_zero}; // see R3
      end
      // route by mode
      case (s_q.mode)
         `ESM_MODE_INT_ONLY:   off_chip = 1'b0;          // see R1
         `ESM_MODE_EXT_ONLY:   off_chip = 1'b1;          // see R9
         default:              off_chip = (eff_addr >> RAM_AW) != 16'h0000; // see R5
      endcase
      // upper lines: 16-bit always, 8-bit only with bank select
      drive_hi = mv_is16 || (s_q.mode == `ESM_MODE_SPLIT_BS); // see R6 see R7 see R8 see R19
   end

   // wrap on the ram size boundary when on-chip
   assign ram_addr = eff_addr[RAM_AW-1:0];               // see R2
   assign ram_we   = (s_q.st == esm_pkg::ESM_IDLE) && mv_req && !off_chip && mv_wr;

   // ---------------------------------------------------------------
   // on-chip ram
   // ---------------------------------------------------------------
   esm_ram #(
      .AW (RAM_AW),
      .DW (8)
   ) u_ram (
      .clk_sys (clk_sys),
      .we      (ram_we),
      .addr    (ram_addr),
      .wdata   (mv_wdata),
      .rdata_q (ram_rdata)
   );

   // ---------------------------------------------------------------
   // next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      s_d      = s_q;
      s_d.done = 1'b0;
      // register writes
      if (sfr_wr) begin
         case (sfr_addr)
            `ESM_OFS_TIMING: s_d.timing = sfr_wdata;
            `ESM_OFS_CONFIG: begin
               s_d.mux_sel = sfr_wdata[`ESM_CF_MUX_BIT];
               s_d.mode    = sfr_wdata[`ESM_CF_MODE_HI:`ESM_CF_MODE_LO];
               s_d.ale_w   = sfr_wdata[`ESM_CF_ALE_HI:`ESM_CF_ALE_LO];
            end
            `ESM_OFS_PAGE:   s_d.page = sfr_wdata;
            default:         s_d.page = s_q.page;
         endcase
      end
      // access sequencer
      case (s_q.st)
         esm_pkg::ESM_IDLE: begin
            if (mv_req) begin
               s_d.addr  = eff_addr;
               s_d.wr    = mv_wr;
               s_d.wdata = mv_wdata;
               s_d.hi_oe = drive_hi;
               if (off_chip) begin
                  s_d.st = esm_pkg::ESM_LEAD;            // see R14
               end else begin
                  s_d.st = esm_pkg::ESM_INT;             // see R23
               end
            end
         end
         esm_pkg::ESM_INT: begin
            s_d.rdata = ram_rdata;
            s_d.done  = 1'b1;
            s_d.st    = esm_pkg::ESM_IDLE;
         end
         esm_pkg::ESM_LEAD: begin
            // muxed bus runs the latch phases first
            if (!s_q.mux_sel) begin
               s_d.st  = esm_pkg::ESM_ALEH;              // see R18 see R20 see R16
               s_d.cnt = {2'b00, s_q.ale_w};             // see R21
            end else if (setup_f != 2'b00) begin
               s_d.st  = esm_pkg::ESM_SETUP;
               s_d.cnt = {2'b00, setup_f - 2'b01};
            end else begin
               s_d.st  = esm_pkg::ESM_STRB;
               s_d.cnt = width_f;
            end
         end
         esm_pkg::ESM_ALEH: begin
            if (s_q.cnt == 4'h0) begin
               s_d.st  = esm_pkg::ESM_ALEL;              // see R22
               s_d.cnt = {2'b00, s_q.ale_w};             // see R21
            end else begin
               s_d.cnt = s_q.cnt - 4'h1;
            end
         end
         esm_pkg::ESM_ALEL: begin
            if (s_q.cnt != 4'h0) begin
               s_d.cnt = s_q.cnt - 4'h1;
            end else if (setup_f != 2'b00) begin
               s_d.st  = esm_pkg::ESM_SETUP;
               s_d.cnt = {2'b00, setup_f - 2'b01};
            end else begin
               s_d.st  = esm_pkg::ESM_STRB;
               s_d.cnt = width_f;
            end
         end
         esm_pkg::ESM_SETUP: begin
            if (s_q.cnt == 4'h0) begin
               s_d.st  = esm_pkg::ESM_STRB;              // see R11 see R23
               s_d.cnt = width_f;
            end else begin
               s_d.cnt = s_q.cnt - 4'h1;
            end
         end
         esm_pkg::ESM_STRB: begin
            if (s_q.cnt == 4'h0) begin
               // sample read data in the last strobe clock
               if (!s_q.wr) begin
                  s_d.rdata = ext_ad_i;                  // see R24
               end
               if (hold_f != 2'b00) begin
                  s_d.st  = esm_pkg::ESM_HOLD;           // see R13
                  s_d.cnt = {2'b00, hold_f - 2'b01};
               end else begin
                  s_d.st  = esm_pkg::ESM_TAIL;
                  s_d.cnt = {2'b00, `ESM_TAIL_LAST};
               end
            end else begin
               s_d.cnt = s_q.cnt - 4'h1;                 // see R12
            end
         end
         esm_pkg::ESM_HOLD: begin
            if (s_q.cnt == 4'h0) begin
               s_d.st  = esm_pkg::ESM_TAIL;
               s_d.cnt = {2'b00, `ESM_TAIL_LAST};
            end else begin
               s_d.cnt = s_q.cnt - 4'h1;
            end
         end
         esm_pkg::ESM_TAIL: begin
            // two closing clocks complete the fixed overhead
            if (s_q.cnt == 4'h0) begin
               s_d.st   = esm_pkg::ESM_IDLE;             // see R14 see R15
               s_d.done = 1'b1;
            end else begin
               s_d.cnt = s_q.cnt - 4'h1;
            end
         end
         default: begin
            s_d.st = esm_pkg::ESM_IDLE;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         s_q         <= '0;
         s_q.st      <= esm_pkg::ESM_IDLE;
         s_q.timing  <= `ESM_TC_RESET;                   // see R17
         s_q.mux_sel <= 1'(`ESM_CF_RESET >> `ESM_CF_MUX_BIT);
         s_q.mode    <= 2'(`ESM_CF_RESET >> `ESM_CF_MODE_LO);
         s_q.ale_w   <= 2'(`ESM_CF_RESET);
         s_q.page    <= `ESM_PAGE_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // ---------------------------------------------------------------
   // register readback
   // ---------------------------------------------------------------
   always_comb begin
      case (sfr_addr)
         `ESM_OFS_TIMING: sfr_rdata = s_q.timing;
         `ESM_OFS_CONFIG: sfr_rdata = {3'b000, s_q.mux_sel, s_q.mode, s_q.ale_w};
         `ESM_OFS_PAGE:   sfr_rdata = s_q.page;
         default:         sfr_rdata = 8'h00;
      endcase
   end

   // ---------------------------------------------------------------
   // core side outputs
   // ---------------------------------------------------------------
   assign mv_busy  = (s_q.st != esm_pkg::ESM_IDLE);
   assign mv_done  = s_q.done;
   assign mv_rdata = s_q.rdata;

   // ---------------------------------------------------------------
   // external pins
   // ---------------------------------------------------------------
   assign bus_active = (s_q.st != esm_pkg::ESM_IDLE) && (s_q.st != esm_pkg::ESM_INT);

   // address lines held from lead through tail
   assign ext_addr_o     = s_q.addr;
   assign ext_addr_hi_oe = bus_active && s_q.hi_oe;      // see R6 see R10
   assign ext_addr_lo_oe = bus_active && s_q.mux_sel;    // see R20

   // latch enable high only in the first latch phase
   assign ext_ale = (s_q.st == esm_pkg::ESM_ALEH);       // see R22

   // strobes only during the strobe phase of an off-chip cycle
   assign ext_rd_n = !((s_q.st == esm_pkg::ESM_STRB) && !s_q.wr); // see R23
   assign ext_wr_n = !((s_q.st == esm_pkg::ESM_STRB) && s_q.wr);  // see R23

   // shared pins: low address in latch phases, write data afterwards
   always_comb begin
      if (!s_q.mux_sel && ((s_q.st == esm_pkg::ESM_ALEH) ||
                           (s_q.st == esm_pkg::ESM_ALEL))) begin
         ext_ad_o  = s_q.addr[7:0];                      // see R22
         ext_ad_oe = 1'b1;
      end else if (s_q.wr && ((s_q.st == esm_pkg::ESM_SETUP) ||
                              (s_q.st == esm_pkg::ESM_STRB) ||
                              (s_q.st == esm_pkg::ESM_HOLD))) begin
         ext_ad_o  = s_q.wdata;
         ext_ad_oe = 1'b1;
      end else begin
         ext_ad_o  = 8'h00;
         ext_ad_oe = 1'b0;
      end
   end

endmodule : esm_ctrl

// [esm_defs.svh]
// register offsets, field positions, reset values and cycle figures
`ifndef ESM_DEFS_SVH
`define ESM_DEFS_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define ESM_OFS_TIMING      8'hAF
`define ESM_OFS_CONFIG      8'hAA
`define ESM_OFS_PAGE        8'hAB

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define ESM_TC_SETUP_HI     7
`define ESM_TC_SETUP_LO     6
`define ESM_TC_WIDTH_HI     5
`define ESM_TC_WIDTH_LO     2
`define ESM_TC_HOLD_HI      1
`define ESM_TC_HOLD_LO      0
`define ESM_CF_MUX_BIT      4
`define ESM_CF_MODE_HI      3
`define ESM_CF_MODE_LO      2
`define ESM_CF_ALE_HI       1
`define ESM_CF_ALE_LO       0

// ---------------------------------------------------------------
// reset values and codes
// ---------------------------------------------------------------
`define ESM_TC_RESET        8'hFF
`define ESM_CF_RESET        5'h00
`define ESM_PAGE_RESET      8'h00
`define ESM_MODE_INT_ONLY   2'h0
`define ESM_MODE_SPLIT_NOBS 2'h1
`define ESM_MODE_SPLIT_BS   2'h2
`define ESM_MODE_EXT_ONLY   2'h3

// ---------------------------------------------------------------
// cycle figures
// ---------------------------------------------------------------
`define ESM_TAIL_LAST       2'h1
`define ESM_RAM_AW_DEF      13

`endif

// [esm_pkg.sv]
// types shared by the external memory steering block
package esm_pkg;

   // access sequencer states, gray coded along the off-chip path
   typedef enum logic [3:0] {
      ESM_IDLE  = 4'h0,
      ESM_LEAD  = 4'h1,
      ESM_ALEH  = 4'h3,
      ESM_ALEL  = 4'h2,
      ESM_SETUP = 4'h6,
      ESM_STRB  = 4'h7,
      ESM_HOLD  = 4'h5,
      ESM_TAIL  = 4'h4,
      ESM_INT   = 4'hC
   } esm_state_t;

endpackage : esm_pkg

// [esm_ram.sv]
// on-chip data ram with registered read data
`timescale 1ns/1ps

module esm_ram #(
   parameter int AW = 13,
   parameter int DW = 8
) (
   input  wire logic          clk_sys,
   input  wire logic          we,
   input  wire logic [AW-1:0] addr,
   input  wire logic [DW-1:0] wdata,
   output logic      [DW-1:0] rdata_q
);

   logic [DW-1:0] mem [0:(1<<AW)-1];

   // read first: a write cycle returns the old data, read data registered
   always_ff @(posedge clk_sys) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata_q <= mem[addr];
   end

endmodule : esm_ram

// [esm_ctrl_properties.sv]
// assertion checker for the external memory steering block
`timescale 1ns/1ps
`include "esm_defs.svh"

module esm_ctrl_props #(
   parameter int RAM_AW = 13
) (
   input wire logic        clk_sys,
   input wire logic        sys_rst,
   input wire logic [7:0]  sfr_addr,
   input wire logic        sfr_wr,
   input wire logic [7:0]  sfr_wdata,
   input wire logic        mv_req,
   input wire logic        mv_is16,
   input wire logic        mv_sel_one,
   input wire logic [15:0] data_pointer,
   input wire logic [7:0]  index_register_zero,
   input wire logic [7:0]  index_register_one,
   input wire logic        mv_busy,
   input wire logic        mv_done,
   input wire logic [15:0] ext_addr_o,
   input wire logic        ext_addr_hi_oe,
   input wire logic        ext_addr_lo_oe,
   input wire logic [7:0]  ext_ad_o,
   input wire logic        ext_ad_oe,
   input wire logic        ext_ale,
   input wire logic        ext_rd_n,
   input wire logic        ext_wr_n
);
   logic [7:0]  tc_q, cf_q, pg_q;
   logic [15:0] eff_q, eff_d;
   logic [5:0]  cnt_q, exp_q, exp_d;
   logic [4:0]  stb_cnt_q;
   logic [2:0]  ale_cnt_q;
   logic        hi_ok_q, off_d, acc, stb_n;

   // a move is taken when idle; either strobe low marks the strobe phase
   assign acc   = mv_req && !mv_busy;
   assign stb_n = ext_rd_n && ext_wr_n;

   // routing and length expected for the move about to be taken
   always_comb begin
      eff_d = mv_is16 ? data_pointer
                      : {pg_q, mv_sel_one ? index_register_one : index_register_zero};
      off_d = cf_q[3:2] == 2'h3 || (cf_q[3:2] != 2'h0 && (eff_d >> RAM_AW) != 16'h0000);
      exp_d = off_d ? 6'h05 + tc_q[7:6] + tc_q[5:2] + tc_q[1:0]
                      + (cf_q[4] ? 6'h00 : 6'h02 * (cf_q[1:0] + 6'h01)) : 6'h02;
   end

   // register mirrors plus move, strobe and latch-phase counters
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         tc_q      <= `ESM_TC_RESET;
         cf_q      <= 8'h00;
         pg_q      <= 8'h00;
         cnt_q     <= 6'h00;
         stb_cnt_q <= 5'h00;
         ale_cnt_q <= 3'h0;
      end else begin
         if (sfr_wr && sfr_addr == `ESM_OFS_TIMING) tc_q <= sfr_wdata;
         if (sfr_wr && sfr_addr == `ESM_OFS_CONFIG) cf_q <= sfr_wdata;
         if (sfr_wr && sfr_addr == `ESM_OFS_PAGE) pg_q <= sfr_wdata;
         if (acc) begin
            cnt_q   <= 6'h01;
            exp_q   <= exp_d;
            eff_q   <= eff_d;
            hi_ok_q <= mv_is16 || cf_q[3:2] == 2'h2;
         end else if (mv_done)
            cnt_q <= 6'h00;
         else if (cnt_q != 6'h00)
            cnt_q <= cnt_q + 6'h01;
         stb_cnt_q <= stb_n ? 5'h00 : stb_cnt_q + 5'h01;
         ale_cnt_q <= ext_ale ? ale_cnt_q + 3'h1 : 3'h0;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   a_move_length: assert property (
      mv_done |-> cnt_q == exp_q) else $error("move length wrong");
   a_setup_len: assert property (
      $fell(stb_n) |-> cnt_q == 6'h02 + tc_q[7:6]
         + (cf_q[4] ? 6'h00 : 6'h02 * (cf_q[1:0] + 6'h01))) else $error("setup wrong");
   a_strobe_width: assert property (
      $rose(stb_n) |-> stb_cnt_q == tc_q[5:2] + 5'h01) else $error("strobe width wrong");
   a_ale_width: assert property (
      $fell(ext_ale) |-> ale_cnt_q == cf_q[1:0] + 3'h1) else $error("latch width wrong");
   a_ale_addr: assert property (
      ext_ale |-> !cf_q[4] && ext_ad_oe && ext_ad_o == eff_q[7:0])
      else $error("latch phase address wrong");
   a_int_quiet: assert property (
      acc && !off_d |=> (stb_n && !ext_ale)[*2]) else $error("on-chip move on bus");
   a_hi_lines: assert property (
      $fell(stb_n) |-> ext_addr_hi_oe == hi_ok_q
         && (!hi_ok_q || ext_addr_o[15:8] == eff_q[15:8])) else $error("upper lines wrong");
   a_lo_lines: assert property (
      $fell(stb_n) |-> ext_addr_lo_oe == cf_q[4]
         && (!cf_q[4] || ext_addr_o[7:0] == eff_q[7:0])) else $error("lower lines wrong");
   a_addr_steady: assert property (
      cnt_q > 6'h01 && mv_busy |-> $stable(ext_addr_o)) else $error("address moved");
   a_strobe_excl: assert property (
      !(!ext_rd_n && !ext_wr_n)) else $error("both strobes low");
   a_write_data: assert property (
      !ext_wr_n |-> ext_ad_oe) else $error("write data not driven");
endmodule : esm_ctrl_props

bind esm_ctrl esm_ctrl_props #(.RAM_AW(RAM_AW)) esm_ctrl_props_inst (
   .clk_sys(clk_sys), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
   .sfr_wdata(sfr_wdata), .mv_req(mv_req), .mv_is16(mv_is16), .mv_sel_one(mv_sel_one),
   .data_pointer(data_pointer), .index_register_zero(index_register_zero),
   .index_register_one(index_register_one), .mv_busy(mv_busy), .mv_done(mv_done),
   .ext_addr_o(ext_addr_o), .ext_addr_hi_oe(ext_addr_hi_oe),
   .ext_addr_lo_oe(ext_addr_lo_oe), .ext_ad_o(ext_ad_o), .ext_ad_oe(ext_ad_oe),
   .ext_ale(ext_ale), .ext_rd_n(ext_rd_n), .ext_wr_n(ext_wr_n)
);

// [esm_sram_model.sv]
// external byte-wide memory with address latch, seen from the bus pins
`timescale 1ns/1ps

module esm_sram_model (
   input  wire logic        clk_sys,
   input  wire logic        slow,
   input  wire logic [15:0] addr,
   input  wire logic        hi_oe,
   input  wire logic        lo_oe,
   input  wire logic [7:0]  port_hi,
   input  wire logic [7:0]  ad_o,
   input  wire logic        ad_oe,
   input  wire logic        ale,
   input  wire logic        rd_n,
   input  wire logic        wr_n,
   output logic      [7:0]  ad_i
);
   logic [7:0]  mem [0:65535];
   logic [7:0]  lat;
   logic [7:0]  last_q = 8'h00;
   logic [3:0]  rd_cnt_q = 4'h0;
   logic [15:0] a;

   // transparent address latch, frozen when ale falls
   always @(ale or ad_o) if (ale) lat = ad_o;

   // undriven upper lines show the port latch value
   assign a = {hi_oe ? addr[15:8] : port_hi, lo_oe ? addr[7:0] : lat};

   // shared pins: read data inside the strobe (from its second clock when slow)
   always_comb begin
      if (ad_oe)
         ad_i = ad_o;
      else if (!rd_n && (!slow || rd_cnt_q != 4'h0))
         ad_i = mem[a];
      else
         ad_i = ~last_q;
   end

   // write capture during the strobe, strobe age, last wire level
   always @(posedge clk_sys) begin
      last_q   <= ad_i;
      rd_cnt_q <= rd_n ? 4'h0 : rd_cnt_q + 4'h1;
      if (!wr_n)
         mem[a] <= ad_o;
   end

   initial for (int i = 0; i < 65536; i++) mem[i] = 8'(i * 7);
endmodule : esm_sram_model

// [tb.sv]
// self-checking bench for the external memory steering block
`timescale 1ns/1ps
`include "esm_defs.svh"

module tb;
   logic        clk_sys = 1'b0;
   logic        sys_rst = 1'b1;
   logic [7:0]  sfr_addr = 8'h00;
   logic        sfr_wr = 1'b0;
   logic [7:0]  sfr_wdata = 8'h00;
   logic        mv_req = 1'b0;
   logic        mv_wr = 1'b0;
   logic        mv_is16 = 1'b0;
   logic        mv_sel_one = 1'b0;
   logic [15:0] dp = 16'h0000;
   logic [7:0]  ir0 = 8'h00;
   logic [7:0]  ir1 = 8'h00;
   logic [7:0]  mv_wdata = 8'h00;
   logic [7:0]  port_hi = 8'h00;
   logic        slow = 1'b0;
   logic [7:0]  sfr_rdata, mv_rdata, ext_ad_i, ext_ad_o, cf, tc, pg, n, rd;
   logic [15:0] ext_addr_o;
   logic        mv_busy, mv_done, hi_oe, lo_oe, ext_ad_oe, ext_ale, rd_n, wr_n;
   logic [31:0] seed = 32'h0000EA8B;
   logic [31:0] r;
   int          mismatches = 0;
   int          check_count = 0;

   esm_ctrl esm_ctrl_inst (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .mv_req(mv_req), .mv_wr(mv_wr),
      .mv_is16(mv_is16), .mv_sel_one(mv_sel_one), .data_pointer(dp),
      .index_register_zero(ir0), .index_register_one(ir1), .mv_wdata(mv_wdata),
      .mv_busy(mv_busy), .mv_done(mv_done), .mv_rdata(mv_rdata), .ext_addr_o(ext_addr_o),
      .ext_addr_hi_oe(hi_oe), .ext_addr_lo_oe(lo_oe), .ext_ad_i(ext_ad_i),
      .ext_ad_o(ext_ad_o), .ext_ad_oe(ext_ad_oe), .ext_ale(ext_ale), .ext_rd_n(rd_n),
      .ext_wr_n(wr_n)
   );
   esm_sram_model esm_sram_model_inst (
      .clk_sys(clk_sys), .slow(slow), .addr(ext_addr_o), .hi_oe(hi_oe), .lo_oe(lo_oe),
      .port_hi(port_hi), .ad_o(ext_ad_o), .ad_oe(ext_ad_oe), .ale(ext_ale),
      .rd_n(rd_n), .wr_n(wr_n), .ad_i(ext_ad_i)
   );

   // system clock, 50 ns period
   initial forever #25 clk_sys = ~clk_sys;

   // xorshift source, fixed start
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   // expected routing, length and bus address of the move set up on the inputs
   function automatic logic off_chip();
      logic [15:0] e;
      e = mv_is16 ? dp : {pg, mv_sel_one ? ir1 : ir0};
      return cf[3:2] == 2'h3 || (cf[3:2] != 2'h0 && e >= 16'h2000);
   endfunction : off_chip
   function automatic logic [7:0] mv_len();
      if (!off_chip())
         return 8'h02;
      return 8'h05 + tc[7:6] + tc[5:2] + tc[1:0] + (cf[4] ? 8'h00 : 8'h02 * (cf[1:0] + 8'h01));
   endfunction : mv_len
   function automatic logic [15:0] ext_at();
      if (mv_is16)
         return dp;
      return {cf[3:2] == 2'h2 ? pg : port_hi, mv_sel_one ? ir1 : ir0};
   endfunction : ext_at

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic tick();
      @(posedge clk_sys);
      #5;
   endtask : tick

   task automatic sfr_w(input logic [7:0] a, input logic [7:0] d);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      tick();
      sfr_wr = 1'b0;
      tick();
   endtask : sfr_w

   task automatic sfr_r(input logic [7:0] a, input logic [7:0] e);
      sfr_addr = a;
      tick();
      chk(sfr_rdata, e);
   endtask : sfr_r

   task automatic setup(input logic [7:0] c, input logic [7:0] t, input logic [7:0] p);
      cf = c;
      tc = t;
      pg = p;
      sfr_w(`ESM_OFS_CONFIG, c);
      sfr_w(`ESM_OFS_TIMING, t);
      sfr_w(`ESM_OFS_PAGE, p);
   endtask : setup

   // one move; n counts clocks from the taking edge to the done cycle
   task automatic mv(input logic w);
      mv_wr = w;
      mv_req = 1'b1;
      n = 8'h00;
      do begin
         tick();
         n++;
         if (n == 8'h01)
            mv_req = 1'b0;
         if (n > 8'h50) begin
            mismatches++;
            end_of_test();
         end
      end while (mv_done !== 1'b1);
      rd = mv_rdata;
   endtask : mv

   // write then read back, back to back, checking length and where the byte landed
   task automatic pair(input logic [7:0] wd);
      mv_wdata = wd;
      mv(1'b1);
      chk(n, mv_len());
      if (off_chip())
         chk(esm_sram_model_inst.mem[ext_at()], wd);
      mv(1'b0);
      chk(rd, wd);
      chk(n, mv_len());
   endtask : pair

   initial begin
      repeat (16) @(posedge clk_sys);
      #5 sys_rst = 1'b0;
      sfr_r(`ESM_OFS_TIMING, 8'hFF);
      sfr_r(`ESM_OFS_CONFIG, 8'h00);
      sfr_w(8'hB0, 8'h5A);
      sfr_r(8'hB0, 8'h00);
      setup(8'hFF, 8'h00, 8'h01);
      sfr_r(`ESM_OFS_CONFIG, 8'h1F);
      // internal only: write, aliased read, then page and index read
      setup(8'h00, 8'h00, 8'h01);
      mv_is16 = 1'b1;
      dp = 16'h0123;
      pair(8'hA5);
      dp = 16'h6123;
      mv(1'b0);
      chk(rd, 8'hA5);
      mv_is16 = 1'b0;
      mv_sel_one = 1'b1;
      ir1 = 8'h23;
      mv(1'b0);
      chk(rd, 8'hA5);
      // shortest off-chip moves into the low range, separate then shared pins
      mv_is16 = 1'b1;
      dp = 16'h0010;
      setup(8'h1C, 8'h00, 8'h00);
      pair(8'h3C);
      chk(n, 8'h05);
      setup(8'h0C, 8'h00, 8'h00);
      pair(8'hC3);
      chk(n, 8'h07);
      // split boundary: last on-chip byte, first off-chip byte
      setup(8'h14, 8'h00, 8'h00);
      dp = 16'h1FFF;
      pair(8'h11);
      chk(n, 8'h02);
      dp = 16'h2000;
      pair(8'h22);
      chk(n, 8'h05);
      // random timing and addresses over every bus style and mode
      for (int k = 0; k < 48; k++) begin
         r = rnd();
         setup({3'h0, k[0], k[2:1], r[1:0]}, r[15:8], r[23:16]);
         r = rnd();
         dp = r[15:0];
         ir0 = r[23:16];
         ir1 = r[31:24];
         r = rnd();
         port_hi = r[7:0];
         mv_is16 = r[8];
         mv_sel_one = r[9];
         slow = r[10] && tc[5:2] != 4'h0;
         pair(r[23:16]);
      end
      end_of_test();
   end
endmodule : tb
